// file: ckvf_regs.vh
// register indices, field positions, reset values for the colour key fader
`ifndef CKVF_REGS_VH
`define CKVF_REGS_VH

// register indices; byte address on the bus is four times the index
`define CKVF_IDX_KEY1_LOWER_U   8'h42
`define CKVF_IDX_KEY1_LOWER_V   8'h43
`define CKVF_IDX_KEY1_LOWER_Y   8'h44
`define CKVF_IDX_KEY2_LOWER_U   8'h45
`define CKVF_IDX_KEY2_LOWER_V   8'h46
`define CKVF_IDX_KEY2_LOWER_Y   8'h47
`define CKVF_IDX_KEY1_UPPER_U   8'h48
`define CKVF_IDX_KEY1_UPPER_V   8'h49
`define CKVF_IDX_KEY1_UPPER_Y   8'h4A
`define CKVF_IDX_KEY2_UPPER_U   8'h4B
`define CKVF_IDX_KEY2_UPPER_V   8'h4C
`define CKVF_IDX_KEY2_UPPER_Y   8'h4D
`define CKVF_IDX_FADE_ONE       8'h4E
`define CKVF_IDX_FILL_FADE_TWO  8'h4F
`define CKVF_IDX_FADE_THREE     8'h50
`define CKVF_IDX_FILL_U         8'h51
`define CKVF_IDX_FILL_V         8'h52
`define CKVF_IDX_FILL_Y         8'h53
`define CKVF_IDX_PATH_CTRL      8'h54
`define CKVF_IDX_STATUS         8'h60

// fields
`define CKVF_FADE_MSB           5
`define CKVF_VIDEO_FILL_BIT     7
`define CKVF_MPEG_FILL_BIT      6
`define CKVF_ENC_SEL_BIT        5
`define CKVF_ST_KEY1_BIT        0
`define CKVF_ST_KEY2_BIT        1
`define CKVF_ST_FILL_BIT        2

// reset values
`define CKVF_RST_LIMIT          8'h80
`define CKVF_RST_FADE           6'h3F
`define CKVF_RST_FILL_COLOUR    8'h80
`define CKVF_RST_FILL_FADE_TWO  8'h3F
`define CKVF_RST_PATH_CTRL      8'h00

// fade arithmetic: weight = factor / full scale, rounded half up
`define CKVF_FADE_FULL          6'h3F
`define CKVF_FADE_ROUND         14'h001F

`endif

// file: ckvf_fader.v
// colour keyed video fader with APB register slave
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "ckvf_regs.vh"

module ckvf_fader #(
	parameter ADDR_WIDTH = 12
) (
	input  wire                  clk,
	input  wire                  resetn,
	input  wire                  psel,
	input  wire                  penable,
	input  wire                  pwrite,
	input  wire [ADDR_WIDTH-1:0] paddr,
	input  wire [31:0]           pwdata,
	input  wire [3:0]            pstrb,
	output reg  [31:0]           prdata,
	output reg                   pready,
	output reg                   pslverr,
	input  wire                  pixValid,
	input  wire [7:0]            vidU,
	input  wire [7:0]            vidV,
	input  wire [7:0]            vidY,
	input  wire [7:0]            mpgU,
	input  wire [7:0]            mpgV,
	input  wire [7:0]            mpgY,
	input  wire [7:0]            mpgBU,
	input  wire [7:0]            mpgBV,
	input  wire [7:0]            mpgBY,
	output reg                   outValid,
	output reg  [7:0]            outU,
	output reg  [7:0]            outV,
	output reg  [7:0]            outY
);

	// configuration registers and the status register
	reg [7:0] key1LowerU_q;
	reg [7:0] key1LowerV_q;
	reg [7:0] key1LowerY_q;
	reg [7:0] key1UpperU_q;
	reg [7:0] key1UpperV_q;
	reg [7:0] key1UpperY_q;
	reg [7:0] key2LowerU_q;
	reg [7:0] key2LowerV_q;
	reg [7:0] key2LowerY_q;
	reg [7:0] key2UpperU_q;
	reg [7:0] key2UpperV_q;
	reg [7:0] key2UpperY_q;
	reg [5:0] fadeOne_q;
	reg [5:0] fadeTwo_q;
	reg [5:0] fadeThree_q;
	reg       videoColourFill_q;
	reg       mpegColourFill_q;
	reg [7:0] fillColourU_q;
	reg [7:0] fillColourV_q;
	reg [7:0] fillColourY_q;
	reg       encoderSourceSelect_q;
	reg [2:0] status_q;

	// first pipeline stage: chosen operands and weight
	reg [7:0] aU_q;
	reg [7:0] aV_q;
	reg [7:0] aY_q;
	reg [7:0] bU_q;
	reg [7:0] bV_q;
	reg [7:0] bY_q;
	reg [5:0] weight_q;
	reg       stageValid_q;

	// x lies inside [lo, hi]; an inverted window never matches
	function inWindow;
		input [7:0] x;
		input [7:0] lo;
		input [7:0] hi;
		begin
			inWindow = (x >= lo) && (x <= hi);
		end
	endfunction

	// all three components inside their windows; shared by both keys
	function keyWindow;
		input [7:0] u;
		input [7:0] v;
		input [7:0] y;
		input [7:0] loU;
		input [7:0] loV;
		input [7:0] loY;
		input [7:0] hiU;
		input [7:0] hiV;
		input [7:0] hiY;
		begin
			keyWindow = inWindow(u, loU, hiU)
				& inWindow(v, loV, hiV)
				& inWindow(y, loY, hiY);
		end
	endfunction

	// f/63 of a plus (63-f)/63 of b, rounded half up
	function [7:0] blend;
		input [5:0] f;
		input [7:0] a;
		input [7:0] b;
		reg   [13:0] sum;
		reg   [13:0] quo;
		begin
			sum = ({8'h00, f} * {6'h00, a})
				+ ({8'h00, `CKVF_FADE_FULL - f} * {6'h00, b})
				+ `CKVF_FADE_ROUND;
			quo = sum / {8'h00, `CKVF_FADE_FULL};
			blend = quo[7:0];
		end
	endfunction

	// bus decode
	// misaligned or high-address accesses are answered with pslverr
	wire [7:0] regIndex = paddr[9:2];
	wire       upperZero;
	wire       access;
	wire       wrStrobe;
	reg        mapped;
	reg [7:0]  readByte;

	generate
		if (ADDR_WIDTH > 10) begin : gUpper
			assign upperZero = ~|paddr[ADDR_WIDTH-1:10];
		end else begin : gNoUpper
			assign upperZero = 1'b1;
		end
	endgenerate

	assign access = psel & penable;
	// write lands only at the edge that completes the transfer
	// pstrb[0] low: the transfer completes but nothing is stored
	assign wrStrobe = access & pready & pwrite & ~pslverr & pstrb[0];

	always @* begin
		mapped = upperZero & (paddr[1:0] == 2'b00);
		readByte = 8'h00;
		case (regIndex)
		`CKVF_IDX_KEY1_LOWER_U: readByte = key1LowerU_q;
		`CKVF_IDX_KEY1_LOWER_V: readByte = key1LowerV_q;
		`CKVF_IDX_KEY1_LOWER_Y: readByte = key1LowerY_q;
		`CKVF_IDX_KEY1_UPPER_U: readByte = key1UpperU_q;
		`CKVF_IDX_KEY1_UPPER_V: readByte = key1UpperV_q;
		`CKVF_IDX_KEY1_UPPER_Y: readByte = key1UpperY_q;
		`CKVF_IDX_KEY2_LOWER_U: readByte = key2LowerU_q;
		`CKVF_IDX_KEY2_LOWER_V: readByte = key2LowerV_q;
		`CKVF_IDX_KEY2_LOWER_Y: readByte = key2LowerY_q;
		`CKVF_IDX_KEY2_UPPER_U: readByte = key2UpperU_q;
		`CKVF_IDX_KEY2_UPPER_V: readByte = key2UpperV_q;
		`CKVF_IDX_KEY2_UPPER_Y: readByte = key2UpperY_q;
		`CKVF_IDX_FADE_ONE:     readByte = {2'b00, fadeOne_q};
		`CKVF_IDX_FILL_FADE_TWO: begin
			readByte = {videoColourFill_q, mpegColourFill_q, fadeTwo_q};
		end
		`CKVF_IDX_FADE_THREE:   readByte = {2'b00, fadeThree_q};
		`CKVF_IDX_FILL_U:       readByte = fillColourU_q;
		`CKVF_IDX_FILL_V:       readByte = fillColourV_q;
		`CKVF_IDX_FILL_Y:       readByte = fillColourY_q;
		`CKVF_IDX_PATH_CTRL: begin
			readByte = {2'b00, encoderSourceSelect_q, 5'b00000};
		end
		`CKVF_IDX_STATUS:       readByte = {5'b00000, status_q};
		default: begin
			mapped = 1'b0;
			readByte = 8'h00;
		end
		endcase
	end

	// one wait state: pready rises in the second access cycle
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (access && !pready) begin
			pready  <= 1'b1;
			pslverr <= ~mapped;
			prdata  <= (mapped && !pwrite) ? {24'h000000, readByte}
			                               : 32'h00000000;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
	end

	// register writes
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			key1LowerU_q <= `CKVF_RST_LIMIT;
			key1LowerV_q <= `CKVF_RST_LIMIT;
			key1LowerY_q <= `CKVF_RST_LIMIT;
			key1UpperU_q <= `CKVF_RST_LIMIT;
			key1UpperV_q <= `CKVF_RST_LIMIT;
			key1UpperY_q <= `CKVF_RST_LIMIT;
			key2LowerU_q <= `CKVF_RST_LIMIT;
			key2LowerV_q <= `CKVF_RST_LIMIT;
			key2LowerY_q <= `CKVF_RST_LIMIT;
			key2UpperU_q <= `CKVF_RST_LIMIT;
			key2UpperV_q <= `CKVF_RST_LIMIT;
			key2UpperY_q <= `CKVF_RST_LIMIT;
			fadeOne_q <= `CKVF_RST_FADE;
			fadeTwo_q <= `CKVF_RST_FADE;
			fadeThree_q <= `CKVF_RST_FADE;
			videoColourFill_q <= 1'b0;
			mpegColourFill_q <= 1'b0;
			fillColourU_q <= `CKVF_RST_FILL_COLOUR;
			fillColourV_q <= `CKVF_RST_FILL_COLOUR;
			fillColourY_q <= `CKVF_RST_FILL_COLOUR;
			encoderSourceSelect_q <= 1'b0;
		end else if (wrStrobe) begin
			case (regIndex)
			`CKVF_IDX_KEY1_LOWER_U: key1LowerU_q <= pwdata[7:0];
			`CKVF_IDX_KEY1_LOWER_V: key1LowerV_q <= pwdata[7:0];
			`CKVF_IDX_KEY1_LOWER_Y: key1LowerY_q <= pwdata[7:0];
			`CKVF_IDX_KEY1_UPPER_U: key1UpperU_q <= pwdata[7:0];
			`CKVF_IDX_KEY1_UPPER_V: key1UpperV_q <= pwdata[7:0];
			`CKVF_IDX_KEY1_UPPER_Y: key1UpperY_q <= pwdata[7:0];
			`CKVF_IDX_KEY2_LOWER_U: key2LowerU_q <= pwdata[7:0];
			`CKVF_IDX_KEY2_LOWER_V: key2LowerV_q <= pwdata[7:0];
			`CKVF_IDX_KEY2_LOWER_Y: key2LowerY_q <= pwdata[7:0];
			`CKVF_IDX_KEY2_UPPER_U: key2UpperU_q <= pwdata[7:0];
			`CKVF_IDX_KEY2_UPPER_V: key2UpperV_q <= pwdata[7:0];
			`CKVF_IDX_KEY2_UPPER_Y: key2UpperY_q <= pwdata[7:0];
			// reserved bits 7:6 are not stored and read back as zero
			`CKVF_IDX_FADE_ONE: begin
				fadeOne_q <= pwdata[`CKVF_FADE_MSB:0];
			end
			`CKVF_IDX_FILL_FADE_TWO: begin
				videoColourFill_q <= pwdata[`CKVF_VIDEO_FILL_BIT];
				mpegColourFill_q <= pwdata[`CKVF_MPEG_FILL_BIT];
				fadeTwo_q <= pwdata[`CKVF_FADE_MSB:0];
			end
			`CKVF_IDX_FADE_THREE: begin
				fadeThree_q <= pwdata[`CKVF_FADE_MSB:0];
			end
			`CKVF_IDX_FILL_U: fillColourU_q <= pwdata[7:0];
			`CKVF_IDX_FILL_V: fillColourV_q <= pwdata[7:0];
			`CKVF_IDX_FILL_Y: fillColourY_q <= pwdata[7:0];
			`CKVF_IDX_PATH_CTRL: begin
				encoderSourceSelect_q <= pwdata[`CKVF_ENC_SEL_BIT];
			end
			default: begin
				encoderSourceSelect_q <= encoderSourceSelect_q;
			end
			endcase
		end
	end

	// key detection on the mpeg sample
	wire key1Hit = keyWindow(mpgU, mpgV, mpgY,
		key1LowerU_q, key1LowerV_q, key1LowerY_q,
		key1UpperU_q, key1UpperV_q, key1UpperY_q);
	wire key2Hit = keyWindow(mpgU, mpgV, mpgY,
		key2LowerU_q, key2LowerV_q, key2LowerY_q,
		key2UpperU_q, key2UpperV_q, key2UpperY_q);
	wire fillActive = videoColourFill_q | mpegColourFill_q;

	// operand selection; weight always applies to the a side
	reg [7:0] aU_d;
	reg [7:0] aV_d;
	reg [7:0] aY_d;
	reg [7:0] bU_d;
	reg [7:0] bV_d;
	reg [7:0] bY_d;
	reg [5:0] weight_d;

	always @* begin
		aU_d = vidU;
		aV_d = vidV;
		aY_d = vidY;
		bU_d = mpgU;
		bV_d = mpgV;
		bY_d = mpgY;
		weight_d = fadeThree_q;
		if (!encoderSourceSelect_q) begin
			// full weight on a reproduces the bypass sample exactly
			aU_d = mpgBU;
			aV_d = mpgBV;
			aY_d = mpgBY;
			weight_d = `CKVF_FADE_FULL;
		end else if (videoColourFill_q) begin
			// video fill outranks mpeg fill if both are set
			bU_d = fillColourU_q;
			bV_d = fillColourV_q;
			bY_d = fillColourY_q;
			weight_d = fadeTwo_q;
		end else if (mpegColourFill_q) begin
			aU_d = mpgU;
			aV_d = mpgV;
			aY_d = mpgY;
			bU_d = fillColourU_q;
			bV_d = fillColourV_q;
			bY_d = fillColourY_q;
			weight_d = fadeTwo_q;
		end else if (key1Hit) begin
			weight_d = fadeOne_q;
		end else if (key2Hit) begin
			bU_d = fillColourU_q;
			bV_d = fillColourV_q;
			bY_d = fillColourY_q;
			weight_d = fadeTwo_q;
		end
	end

	// stage one: capture operands and the per-sample status
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			aU_q <= 8'h00;
			aV_q <= 8'h00;
			aY_q <= 8'h00;
			bU_q <= 8'h00;
			bV_q <= 8'h00;
			bY_q <= 8'h00;
			weight_q <= 6'h00;
			stageValid_q <= 1'b0;
			status_q <= 3'b000;
		end else begin
			stageValid_q <= pixValid;
			if (pixValid) begin
				aU_q <= aU_d;
				aV_q <= aV_d;
				aY_q <= aY_d;
				bU_q <= bU_d;
				bV_q <= bV_d;
				bY_q <= bY_d;
				weight_q <= weight_d;
				// keys read as not hit while a fill mode holds them off
				status_q[`CKVF_ST_KEY1_BIT] <= key1Hit & ~fillActive;
				status_q[`CKVF_ST_KEY2_BIT] <= key2Hit & ~fillActive;
				status_q[`CKVF_ST_FILL_BIT] <= fillActive;
			end
		end
	end

	// stage two: the blend; division by a constant stays in one cycle
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			outValid <= 1'b0;
			outU <= 8'h00;
			outV <= 8'h00;
			outY <= 8'h00;
		end else begin
			outValid <= stageValid_q;
			if (stageValid_q) begin
				outU <= blend(weight_q, aU_q, bU_q);
				outV <= blend(weight_q, aV_q, bV_q);
				outY <= blend(weight_q, aY_q, bY_q);
			end
		end
	end

endmodule

// file: ckvf_fader_checker.sv
// port assertions for the colour key fader
`timescale 1ns/1ps
module ckvf_fader_checker #(
	parameter ADDR_WIDTH = 12
) (
	input wire logic                  clk,
	input wire logic                  resetn,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic                  pixValid,
	input wire logic                  outValid,
	input wire logic [7:0]            outU,
	input wire logic [7:0]            outV,
	input wire logic [7:0]            outY
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	chk_out_latency: assert property (pixValid |-> ##2 outValid)
		else $error("sample result missing two cycles later");
	chk_out_cause: assert property (outValid |-> $past(pixValid, 2))
		else $error("result without a sample");
	chk_out_hold: assert property (!outValid |-> $stable({outU, outV, outY}))
		else $error("output changed without a result");
	chk_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("access not answered after one wait state");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	chk_err_ready: assert property (pslverr |-> pready && psel && penable)
		else $error("error outside an answer");
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside an answer");
	chk_misalign_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned access not refused");
	chk_rdata_byte: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("read data above the byte");
	cover property (pready && pslverr);
	cover property (pready && pwrite && !pslverr);
	cover property (outValid);
endmodule

bind ckvf_fader ckvf_fader_checker #(.ADDR_WIDTH(ADDR_WIDTH)) chk (.*);

// file: ckvf_pixel_source.sv
// upstream video and compressed-video pixel source model
`timescale 1ns/1ps
module ckvf_pixel_source (
	input  wire logic       clk,
	output      logic       pixValid,
	output      logic [7:0] vidU,
	output      logic [7:0] vidV,
	output      logic [7:0] vidY,
	output      logic [7:0] mpgU,
	output      logic [7:0] mpgV,
	output      logic [7:0] mpgY,
	output      logic [7:0] mpgBU,
	output      logic [7:0] mpgBV,
	output      logic [7:0] mpgBY
);
	initial begin
		pixValid = 1'b0;
		{vidU, vidV, vidY, mpgU, mpgV, mpgY, mpgBU, mpgBV, mpgBY} = 72'h0;
	end
	task send(input logic [23:0] v, input logic [23:0] m, input logic [23:0] b);
		@(posedge clk);
		pixValid <= 1'b1;
		{vidU, vidV, vidY} <= v;
		{mpgU, mpgV, mpgY} <= m;
		{mpgBU, mpgBV, mpgBY} <= b;
		@(posedge clk);
		pixValid <= 1'b0;
		// idle lines must not keep showing the sample just taken
		{vidU, vidV, vidY} <= ~v;
		{mpgU, mpgV, mpgY} <= ~m;
		{mpgBU, mpgBV, mpgBY} <= ~b;
	endtask
endmodule

// file: tb_ckvf_fader.sv
// self-checking bench for the colour key fader
`timescale 1ns/1ps
`include "ckvf_regs.vh"
module tb_ckvf_fader;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'hF;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pixValid;
	logic        outValid;
	logic [7:0]  vidU, vidV, vidY, mpgU, mpgV, mpgY, mpgBU, mpgBV, mpgBY;
	logic [7:0]  outU, outV, outY;
	logic [31:0] rd;
	logic        err;
	int          miscompares = 0;
	int          comparisons = 0;
	logic [7:0]  ri [12] = '{8'h45, 8'h46, 8'h47, 8'h4B, 8'h4C, 8'h4D,
		8'h4E, 8'h4F, 8'h50, 8'h51, 8'h52, 8'h53};
	localparam logic [23:0] V = 24'hC8_40_E0;
	localparam logic [23:0] B = 24'h5A_A5_3C;
	localparam logic [23:0] F = 24'h11_22_33;
	localparam logic [23:0] K = 24'h80_80_80;
	localparam logic [23:0] H = 24'h90_95_A0;

	ckvf_fader uut (.*);
	ckvf_pixel_source src (.*);

	initial forever #5 clk = ~clk;
	initial begin
		#100000;
		miscompares++;
		report_and_stop;
	end

	task report_and_stop;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one APB transfer; waits for pready whatever the slave latency
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] i, input logic [7:0] d);
		apb(1'b1, {2'h0, i, 2'h0}, d);
	endtask
	task rdc(input logic [7:0] i, input logic [7:0] e);
		apb(1'b0, {2'h0, i, 2'h0}, 8'h00);
		check({err, rd[30:0]}, {1'b0, 23'h0, e});
	endtask
	function automatic logic [7:0] bl(input int f, input int a, input int b);
		return 8'((f * a + (63 - f) * b + 31) / 63);
	endfunction
	function automatic logic [23:0] bl3(int f, logic [23:0] a, logic [23:0] b);
		return {bl(f, a[23:16], b[23:16]), bl(f, a[15:8], b[15:8]),
			bl(f, a[7:0], b[7:0])};
	endfunction
	task px(input logic [23:0] m, input logic [23:0] e);
		int n;
		src.send(V, m, B);
		n = 0;
		while (outValid !== 1'b1 && n < 8) begin
			@(posedge clk);
			n++;
		end
		check({7'h0, outValid, outU, outV, outY}, {8'h01, e});
	endtask

	initial begin
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 12; i++)
			rdc(ri[i], (i > 5 && i < 9) ? 8'h3F : 8'h80);
		apb(1'b0, 12'hFFC, 8'h00);
		check({err, rd[30:0]}, {1'b1, 31'h0});
		apb(1'b1, 12'h139, 8'h00);
		check({31'h0, err}, 32'h1);
		pstrb <= 4'h0;
		wr(`CKVF_IDX_FADE_ONE, 8'h00);
		pstrb <= 4'hF;
		rdc(`CKVF_IDX_FADE_ONE, 8'h3F);
		px(H, B);
		wr(`CKVF_IDX_PATH_CTRL, 8'h20);
		rdc(`CKVF_IDX_PATH_CTRL, 8'h20);
		px(H, V);
		wr(`CKVF_IDX_FADE_THREE, 8'h00);
		px(H, H);
		wr(`CKVF_IDX_FADE_THREE, 8'h15);
		px(H, bl3(21, V, H));
		wr(`CKVF_IDX_FADE_ONE, 8'h00);
		px(K, K);
		wr(`CKVF_IDX_FADE_ONE, 8'h2A);
		px(K, bl3(42, V, K));
		rdc(`CKVF_IDX_STATUS, 8'h03);
		for (int i = 0; i < 3; i++) begin
			wr(8'(`CKVF_IDX_KEY2_LOWER_U + i), 8'h90);
			wr(8'(`CKVF_IDX_KEY2_UPPER_U + i), 8'hA0);
			wr(8'(`CKVF_IDX_FILL_U + i), F[23 - 8 * i -: 8]);
		end
		wr(`CKVF_IDX_FILL_FADE_TWO, 8'h00);
		px(H, F);
		wr(`CKVF_IDX_FILL_FADE_TWO, 8'h0D);
		px(H, bl3(13, V, F));
		px(24'h90_95_A1, bl3(21, V, 24'h90_95_A1));
		px(24'h8F_95_A0, bl3(21, V, 24'h8F_95_A0));
		wr(`CKVF_IDX_FILL_FADE_TWO, 8'h8D);
		px(K, bl3(13, V, F));
		wr(`CKVF_IDX_FILL_FADE_TWO, 8'h4D);
		px(K, bl3(13, K, F));
		rdc(`CKVF_IDX_FILL_FADE_TWO, 8'h4D);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		rdc(`CKVF_IDX_FILL_FADE_TWO, 8'h3F);
		rdc(`CKVF_IDX_PATH_CTRL, 8'h00);
		px(H, B);
		report_and_stop;
	end
endmodule
